// ### rtl/serial_port_regs.svh
// constants for the two-wire register port
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
`define ADDR_FIXED_BITS 5'h18
`define SUB_ADDR_LAST 8'h7f
`define REG_COUNT 128
`define RESET_READY_US 50
`define CLK_MHZ 125
`define READY_CYCLES (`RESET_READY_US * `CLK_MHZ)
`define HW_RESET_MIN_US 1000
`define HW_RESET_CYCLES (`HW_RESET_MIN_US * `CLK_MHZ)
`define SCL_HALF_CYCLES 10
`define STRAP_LVL_00 2'h0
`define STRAP_LVL_01 2'h1
`define STRAP_LVL_10 2'h2
`define STRAP_LVL_11 2'h3
`define RO_FIRST 8'h78
`endif

// ### rtl/serial_port_pkg.sv
// types for the two-wire register port
package serial_port_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [1:0] strap_t;
endpackage : serial_port_pkg

// ### rtl/serial_link_if.sv
// two-wire link joining host and tuner port
`timescale 1ns/1ps
interface serial_link_if;
   logic scl_o;
   logic scl_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic hw_reset_n;
   wire scl = scl_oe ? scl_o : 1'b1;
   wire sda = (sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o) ? 1'b0 : 1'b1;
   modport host (output scl_o, output scl_oe, output sda_host_o, output sda_host_oe,
      output hw_reset_n, input sda);
   modport device (input scl, input sda, input hw_reset_n, output sda_dev_o,
      output sda_dev_oe);
endinterface : serial_link_if

// ### rtl/tuner_serial_register_port.sv
// device end: two-wire slave holding the 8-bit sub-addressed registers
// Functional notes
// - sub address 8 bits, registers 00h-7Fh only
// - sub address increments after each byte
// - no limit on burst length
// - writes to read-only locations are dropped
// - port logic samples the bus on the reference clock
// - slave address C0/C2/C4/C6 from strap
// - strap voltage band sets two address bits
// - address LSB selects write or read
// - host writes address, sub address, data
// - host reads via repeated start sequence
// - stop then start keeps read pointer
// - host holds reset low at least 1ms
// - bus usable 50us after reset release
// - hardware reset active low, mandatory
`timescale 1ns/1ps
`include "serial_port_regs.svh"
module tuner_serial_register_port (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // strap: band index decoded from the analog select pin level
   input wire serial_port_pkg::strap_t addr_strap_pin,
   // link
   serial_link_if.device link,
   // status
   output logic ready,
   output serial_port_pkg::byte_t last_sub_addr
);
   import serial_port_pkg::*;
   ////////////////////////////////////////////////////////////////////
   // pin synchronisers: scl and sda changes and reset release count once stages two and three agree
   logic [2:0] scl_s_r;
   logic [2:0] sda_s_r;
   logic [2:0] rst_s_r;
   logic scl_f_r;
   logic sda_f_r;
   always_ff @(posedge clock) begin
      if (!rstn) begin
         scl_s_r <= 3'h7;
         sda_s_r <= 3'h7;
         rst_s_r <= 3'h0;
         scl_f_r <= 1'b1;
         sda_f_r <= 1'b1;
      end else begin
         scl_s_r <= {scl_s_r[1:0], link.scl};
         sda_s_r <= {sda_s_r[1:0], link.sda};
         rst_s_r <= {rst_s_r[1:0], link.hw_reset_n};
         if (scl_s_r[1] == scl_s_r[2])
            scl_f_r <= scl_s_r[2];
         if (sda_s_r[1] == sda_s_r[2])
            sda_f_r <= sda_s_r[2];
      end
   end
   wire hw_rst_n = rst_s_r[2] & rst_s_r[1];
   wire port_rst = !rstn || !hw_rst_n;
   wire scl_f_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
   wire sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
   wire scl_rise = scl_f_nxt & ~scl_f_r;
   wire scl_fall = ~scl_f_nxt & scl_f_r;
   // conditions taken from the filtered scl and sda samples on the reference clock
   wire start_cond = scl_f_r & scl_f_nxt & sda_f_r & ~sda_f_nxt;
   wire stop_cond = scl_f_r & scl_f_nxt & ~sda_f_r & sda_f_nxt;
   ////////////////////////////////////////////////////////////////////
   // strap capture after reset release
   logic [1:0] strap_r;
   logic strap_done_r;
   logic [12:0] ready_cnt_r;
   always_ff @(posedge clock) begin
      if (port_rst) begin
         strap_r <= 2'h0;
         strap_done_r <= 1'b0;
         ready_cnt_r <= 13'h0000;
      end else begin
         if (!strap_done_r)
            strap_r <= addr_strap_pin;
         strap_done_r <= 1'b1;
         if (ready_cnt_r != 13'(`READY_CYCLES))
            ready_cnt_r <= ready_cnt_r + 13'h0001;
      end
   end
   assign ready = (ready_cnt_r == 13'(`READY_CYCLES));
   // fixed five bits then strap pair
   wire [6:0] own_addr = {`ADDR_FIXED_BITS, strap_r};
   ////////////////////////////////////////////////////////////////////
   // byte engine
   typedef enum {IDLE, ADDR, ACK_A, SUB, ACK_S, WDATA, ACK_W, RDATA, ACK_R, IGNORE} st_t;
   st_t st_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic [7:0] sub_r;
   logic ack_drv_r;
   logic [7:0] regs_r [`REG_COUNT];
   assign last_sub_addr = sub_r;
   wire [7:0] sh_nxt = {sh_r[6:0], sda_f_r};
   // only the low half of the sub address space exists
   wire sub_ok = (sub_r <= `SUB_ADDR_LAST);
   wire sub_wr_ok = sub_ok && (sub_r < `RO_FIRST);
   wire [7:0] rd_byte = sub_ok ? regs_r[sub_r[6:0]] : 8'h00;
   wire addr_hit = (sh_r[7:1] == own_addr);
   always_ff @(posedge clock) begin
      if (port_rst || !ready) begin
         st_r <= IDLE;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         ack_drv_r <= 1'b0;
      end else if (start_cond) begin
         st_r <= ADDR;
         bit_r <= 4'h0;
         ack_drv_r <= 1'b0;
      end else if (stop_cond) begin
         st_r <= IDLE;
         ack_drv_r <= 1'b0;
      end else if (scl_rise && (st_r == ADDR || st_r == SUB || st_r == WDATA)) begin
         sh_r <= sh_nxt;
         bit_r <= bit_r + 4'h1;
      end else if (scl_rise && st_r == ACK_R) begin
         // master nack ends the read
         if (sda_f_r)
            st_r <= IGNORE;
      end else if (scl_fall) begin
         case (st_r)
            ADDR, SUB, WDATA: begin
               if (bit_r == 4'h8) begin
                  bit_r <= 4'h0;
                  ack_drv_r <= (st_r != ADDR) || addr_hit;
                  case (st_r)
                     ADDR: st_r <= addr_hit ? ACK_A : IGNORE;
                     SUB: st_r <= ACK_S;
                     default: st_r <= ACK_W;
                  endcase
               end
            end
            ACK_A: begin
               ack_drv_r <= 1'b0;
               if (sh_r[0]) begin
                  st_r <= RDATA;
                  sh_r <= rd_byte;
               end else
                  st_r <= SUB;
            end
            ACK_S: begin
               ack_drv_r <= 1'b0;
               st_r <= WDATA;
            end
            ACK_W: begin
               ack_drv_r <= 1'b0;
               st_r <= WDATA;
            end
            RDATA: begin
               if (bit_r == 4'h7) begin
                  bit_r <= 4'h0;
                  st_r <= ACK_R;
               end else begin
                  bit_r <= bit_r + 4'h1;
                  sh_r <= {sh_r[6:0], 1'b0};
               end
            end
            ACK_R: begin
               st_r <= RDATA;
               sh_r <= rd_byte;
            end
            default: st_r <= st_r;
         endcase
      end
   end
   // sub address pointer and register writes
   always_ff @(posedge clock) begin
      if (port_rst) begin
         sub_r <= 8'h00;
      end else if (ready && !start_cond && !stop_cond && scl_fall) begin
         if (st_r == SUB && bit_r == 4'h8)
            sub_r <= sh_r;
         else if ((st_r == WDATA && bit_r == 4'h8) || (st_r == RDATA && bit_r == 4'h7))
            sub_r <= sub_r + 8'h01;
      end
   end
   wire wr_en = ready && scl_fall && st_r == WDATA && bit_r == 4'h8 && sub_wr_ok
      && !start_cond && !stop_cond;
   genvar gi;
   generate
      for (gi = 0; gi < `REG_COUNT; gi++) begin : g_reg
         always_ff @(posedge clock) begin
            if (port_rst)
               regs_r[gi] <= 8'h00;
            else if (wr_en && sub_r[6:0] == 7'(gi))
               regs_r[gi] <= sh_r;
         end
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////
   // open-drain data drive: low only
   wire drive_rd = (st_r == RDATA) && !sh_r[7];
   assign link.sda_dev_o = 1'b0;
   assign link.sda_dev_oe = ack_drv_r | drive_rd;
endmodule : tuner_serial_register_port

// ### rtl/serial_host_master.sv
// host end: bus master issuing register writes and reads
`timescale 1ns/1ps
`include "serial_port_regs.svh"
module serial_host_master #(
   parameter int RESET_CYCLES = `HW_RESET_CYCLES,
   parameter int READY_WAIT = `READY_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // request
   input wire logic req_valid,
   input wire logic req_read,
   input wire serial_port_pkg::strap_t req_strap,
   input wire serial_port_pkg::byte_t req_sub,
   input wire serial_port_pkg::byte_t req_data,
   output logic req_ready,
   // answer
   output logic done,
   output logic nack,
   output serial_port_pkg::byte_t rd_data,
   // link
   serial_link_if.host link
);
   import serial_port_pkg::*;
   typedef enum {RST, WAIT, IDLE, START, BITS, STOP, RESTART} st_t;
   st_t st_r;
   logic [17:0] cnt_r;
   logic [7:0] tx_r [3];
   logic [1:0] byte_r;
   logic [1:0] nbytes_r;
   logic [3:0] bit_r;
   logic [1:0] ph_r;
   logic rd_r;
   logic [7:0] rx_r;
   logic nack_r;
   logic [2:0] sda_s_r;
   logic scl_r;
   logic sda_r;
   logic done_r;
   logic split_r;
   always_ff @(posedge clock) begin
      if (!rstn)
         sda_s_r <= 3'h7;
      else
         sda_s_r <= {sda_s_r[1:0], link.sda};
   end
   wire sda_in = sda_s_r[2];
   wire half = (cnt_r == 18'(`SCL_HALF_CYCLES));
   // reset and settle waits count past the bit-phase wrap
   wire long_wait = (st_r == RST) || (st_r == WAIT);
   wire cnt_wrap = half && !long_wait;
   wire last_bit = (bit_r == 4'h8);
   wire in_read_byte = rd_r && byte_r == nbytes_r;
   assign req_ready = (st_r == IDLE);
   assign link.scl_o = scl_r;
   assign link.scl_oe = 1'b1;
   assign link.sda_host_o = sda_r;
   assign link.sda_host_oe = 1'b1;
   assign link.hw_reset_n = !(st_r == RST);
   assign done = done_r;
   assign nack = nack_r;
   assign rd_data = rx_r;
   always_ff @(posedge clock) begin
      if (!rstn) begin
         st_r <= RST;
         cnt_r <= 18'h0_0000;
         scl_r <= 1'b1;
         sda_r <= 1'b1;
         byte_r <= 2'h0;
         nbytes_r <= 2'h0;
         bit_r <= 4'h0;
         ph_r <= 2'h0;
         rd_r <= 1'b0;
         rx_r <= 8'h00;
         nack_r <= 1'b0;
         done_r <= 1'b0;
         split_r <= 1'b0;
         for (int i = 0; i < 3; i++)
            tx_r[i] <= 8'h00;
      end else begin
         done_r <= 1'b0;
         cnt_r <= cnt_wrap ? 18'h0_0000 : cnt_r + 18'h0_0001;
         case (st_r)
            RST: if (cnt_r == 18'(RESET_CYCLES)) begin
               st_r <= WAIT;
               cnt_r <= 18'h0_0000;
            end
            WAIT: if (cnt_r == 18'(READY_WAIT))
               st_r <= IDLE;
            IDLE: begin
               cnt_r <= 18'h0_0000;
               if (req_valid) begin
                  tx_r[0] <= {`ADDR_FIXED_BITS, req_strap, 1'b0};
                  tx_r[1] <= req_sub;
                  // read reissues address with lsb set
                  tx_r[2] <= req_read ? {`ADDR_FIXED_BITS, req_strap, 1'b1} : req_data;
                  rd_r <= req_read;
                  nbytes_r <= 2'h2;
                  byte_r <= 2'h0;
                  nack_r <= 1'b0;
                  // read with data bit 0 set: stop and start instead of repeated start
                  split_r <= req_read && req_data[0];
                  st_r <= START;
               end
            end
            START: if (half) begin
               sda_r <= 1'b0;
               st_r <= BITS;
               bit_r <= 4'h0;
               ph_r <= 2'h0;
            end
            BITS: if (half) begin
               ph_r <= ph_r + 2'h1;
               case (ph_r)
                  2'h0: begin
                     scl_r <= 1'b0;
                  end
                  // ack slots and the read byte leave sda released; last read byte nacked
                  2'h1: sda_r <= (last_bit || byte_r == 2'h3) ? 1'b1 : tx_r[byte_r][7 - bit_r];
                  2'h2: scl_r <= 1'b1;
                  default: begin
                     ph_r <= 2'h0;
                     if (byte_r == 2'h3 && !last_bit)
                        rx_r <= {rx_r[6:0], sda_in};
                     if (last_bit && byte_r != 2'h3 && sda_in)
                        nack_r <= 1'b1;
                     if (!last_bit)
                        bit_r <= bit_r + 4'h1;
                     else begin
                        bit_r <= 4'h0;
                        if (rd_r && byte_r == 2'h1) begin
                           st_r <= RESTART;
                           byte_r <= 2'h2;
                        end else if (byte_r == nbytes_r || byte_r == 2'h3 || sda_in)
                           st_r <= STOP;
                        else if (in_read_byte)
                           byte_r <= 2'h3;
                        else
                           byte_r <= byte_r + 2'h1;
                        if (rd_r && byte_r == 2'h2 && !sda_in) begin
                           st_r <= BITS;
                           byte_r <= 2'h3;
                        end
                     end
                  end
               endcase
            end
            RESTART: if (half) begin
               ph_r <= ph_r + 2'h1;
               case (ph_r)
                  2'h0: scl_r <= 1'b0;
                  // split read parks sda low so a stop comes first
                  2'h1: sda_r <= !split_r;
                  2'h2: scl_r <= 1'b1;
                  default: begin
                     if (split_r) begin
                        sda_r <= 1'b1;
                        split_r <= 1'b0;
                        ph_r <= 2'h3;
                     end else begin
                        sda_r <= 1'b0;
                        ph_r <= 2'h0;
                        st_r <= BITS;
                     end
                  end
               endcase
            end
            STOP: if (half) begin
               ph_r <= ph_r + 2'h1;
               case (ph_r)
                  2'h0: scl_r <= 1'b0;
                  2'h1: sda_r <= 1'b0;
                  2'h2: scl_r <= 1'b1;
                  default: begin
                     sda_r <= 1'b1;
                     ph_r <= 2'h0;
                     done_r <= 1'b1;
                     st_r <= IDLE;
                  end
               endcase
            end
            default: st_r <= RST;
         endcase
      end
   end
endmodule : serial_host_master

// ### tb/serial_link_sva.sv
// assertions on the two-wire link between host end and tuner port
`timescale 1ns/1ps
module serial_link_sva #(
   parameter int RESET_CYCLES = 20
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // link
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic hw_reset_n
);
   localparam int READY_MIN = 6250;
   int unsigned up_cnt_r;
   int unsigned low_cnt_r;
   ////////////////////////////////////////////////////////////////////////////////
   // saturating, so a long run cannot wrap back under the limit
   always_ff @(posedge clock) begin
      if (!rstn || !hw_reset_n) begin
         up_cnt_r <= 0;
      end else if (up_cnt_r < 100000) begin
         up_cnt_r <= up_cnt_r + 1;
      end
   end
   // reset itself counts as low time
   always_ff @(posedge clock) begin
      if (!rstn) begin
         low_cnt_r <= 1;
      end else if (hw_reset_n) begin
         low_cnt_r <= 0;
      end else begin
         low_cnt_r <= low_cnt_r + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_rst_held;
      !hw_reset_n [*4];
   endsequence
   sequence s_drive_start;
      $rose(sda_dev_oe) ##0 !scl;
   endsequence
   property p_rst_quiet;
      s_rst_held |-> !sda_dev_oe;
   endproperty
   property p_ready_gap;
      sda_dev_oe |-> up_cnt_r >= READY_MIN;
   endproperty
   property p_host_gap;
      $fell(sda) && scl |-> up_cnt_r >= READY_MIN - 1;
   endproperty
   property p_rst_len;
      $rose(hw_reset_n) |-> low_cnt_r >= RESET_CYCLES;
   endproperty
   property p_dev_rise_low;
      $rose(sda_dev_oe) |-> !scl;
   endproperty
   property p_dev_fall_low;
      $fell(sda_dev_oe) |-> !scl;
   endproperty
   property p_dev_hold;
      scl && $past(scl) |-> $stable(sda_dev_oe);
   endproperty
   property p_ack_stands;
      s_drive_start |=> sda_dev_oe [*4];
   endproperty
   property p_dev_pull_low;
      sda_dev_oe |-> !sda_dev_o;
   endproperty
   // longest legal drive is an ack plus eight zero bits
   property p_dev_release;
      sda_dev_oe |-> ##[1:500] !sda_dev_oe;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("device drives data during reset");
   a_ready_gap: assert property (p_ready_gap) else $error("device answers too soon");
   a_host_gap: assert property (p_host_gap) else $error("host starts too soon");
   a_rst_len: assert property (p_rst_len) else $error("reset pulse too short");
   a_dev_rise_low: assert property (p_dev_rise_low) else $error("device drive starts in clock high");
   a_dev_fall_low: assert property (p_dev_fall_low) else $error("device release in clock high");
   a_dev_hold: assert property (p_dev_hold) else $error("device data moves in clock high");
   a_ack_stands: assert property (p_ack_stands) else $error("device drive too short");
   a_dev_pull_low: assert property (p_dev_pull_low) else $error("device drives data high");
   a_dev_release: assert property (p_dev_release) else $error("device holds data low");
endmodule : serial_link_sva

// ### tb/tb.sv
// self-checking bench joining host end and tuner port over the link
`timescale 1ns/1ps
module tb;
   import serial_port_pkg::*;
   localparam strap_t DEV_STRAP = 2'h2;
   strap_t dev_strap;
   logic clock;
   logic rstn;
   logic req_valid;
   logic req_read;
   strap_t req_strap;
   byte_t req_sub;
   byte_t req_data;
   logic req_ready;
   logic done;
   logic nack;
   logic ready;
   byte_t rd_data;
   byte_t last_sub_addr;
   int errors;
   int num_checks;
   int cycles;
   byte_t subs[4] = '{8'h77, 8'h78, 8'h7f, 8'h80};
   byte_t exps[4] = '{8'hc3, 8'h00, 8'h00, 8'h00};
   serial_link_if link();
   serial_host_master #(.RESET_CYCLES(20), .READY_WAIT(6250)) i_serial_host_master (
      .clock(clock), .rstn(rstn), .req_valid(req_valid), .req_read(req_read),
      .req_strap(req_strap), .req_sub(req_sub), .req_data(req_data), .req_ready(req_ready),
      .done(done), .nack(nack), .rd_data(rd_data), .link(link));
   tuner_serial_register_port i_tuner_serial_register_port (
      .clock(clock), .rstn(rstn), .addr_strap_pin(dev_strap), .link(link), .ready(ready),
      .last_sub_addr(last_sub_addr));
   serial_link_sva #(.RESET_CYCLES(20)) i_serial_link_sva (
      .clock(clock), .rstn(rstn), .scl(link.scl), .sda(link.sda), .sda_dev_o(link.sda_dev_o),
      .sda_dev_oe(link.sda_dev_oe), .hw_reset_n(link.hw_reset_n));
   ////////////////////////////////////////////////////////////////////////////////
   task test_done;
      $display("checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done
   task chk8(input string what, input byte_t exp, input byte_t got);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         errors++;
      end
   endtask : chk8
   task chk1(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
         errors++;
      end
   endtask : chk1
   // one request; waits are bounded, a hang ends the test with an error at the wait bound
   task xfer(input logic rd, input strap_t st, input byte_t sub, input byte_t dat);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 20000) begin
         @(negedge clock);
         n++;
      end
      if (n >= 20000) begin
         errors++;
         test_done();
      end
      req_read = rd;
      req_strap = st;
      req_sub = sub;
      req_data = dat;
      req_valid = 1'b1;
      @(negedge clock);
      req_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 5000) begin
         @(negedge clock);
         n++;
      end
      if (n >= 5000) begin
         errors++;
         test_done();
      end
   endtask : xfer
   task do_reset;
      rstn = 1'b0;
      repeat (4) @(negedge clock);
      rstn = 1'b1;
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         errors++;
         test_done();
      end
   end
   initial begin
      cycles = 0;
      errors = 0;
      num_checks = 0;
      req_valid = 1'b0;
      req_read = 1'b0;
      req_strap = DEV_STRAP;
      req_sub = 8'h00;
      req_data = 8'h00;
      dev_strap = DEV_STRAP;
      do_reset();
      xfer(1'b1, DEV_STRAP, 8'h00, 8'h00);
      chk8("reset value", 8'h00, rd_data);
      chk1("port ready", 1'b1, ready);
      xfer(1'b0, DEV_STRAP, 8'h05, 8'ha5);
      chk1("write nack", 1'b0, nack);
      chk8("pointer", 8'h06, last_sub_addr);
      xfer(1'b1, DEV_STRAP, 8'h05, 8'h00);
      chk8("read back", 8'ha5, rd_data);
      // last writable place, read-only places, then past the map
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, DEV_STRAP, subs[i], 8'h3c ^ {8{i == 0}});
         xfer(1'b1, DEV_STRAP, subs[i], 8'h00);
         chk8("map read", exps[i], rd_data);
      end
      for (int s = 0; s < 4; s++) begin
         xfer(1'b0, strap_t'(s), 8'h10, 8'h50 + byte_t'(s));
         chk1("addr match", s != 2, nack);
      end
      xfer(1'b1, DEV_STRAP, 8'h10, 8'h00);
      chk8("only matched write", 8'h52, rd_data);
      // new strap only takes effect through a reset
      dev_strap = 2'h1;
      do_reset();
      xfer(1'b1, 2'h1, 8'h05, 8'h00);
      chk8("cleared by reset", 8'h00, rd_data);
      xfer(1'b0, DEV_STRAP, 8'h20, 8'h6b);
      chk1("old strap refused", 1'b1, nack);
      xfer(1'b0, 2'h1, 8'h20, 8'h6b);
      xfer(1'b1, 2'h1, 8'h20, 8'h01);
      chk8("split read", 8'h6b, rd_data);
      chk8("pointer after read", 8'h21, last_sub_addr);
      test_done();
   end
endmodule : tb
